// [pnc_pkg.sv]
// Purpose: constants for the protection and default-store command handler
// Assumes: 8-bit command codes and data bytes, one clock
// Notes: operating-memory items are indexed 0..PNC_ITEMS-1
package pnc_pkg;
	// ------------------------------------------------------------
	// command codes
	// ------------------------------------------------------------
	localparam logic [7:0] CODE_OPERATION = 8'h01;
	localparam logic [7:0] CODE_ON_OFF_CFG = 8'h02;
	localparam logic [7:0] CODE_CLEAR_FLAGS = 8'h03;
	localparam logic [7:0] CODE_WRITE_GUARD = 8'h10;
	localparam logic [7:0] CODE_NVM_STORE = 8'h11;
	localparam logic [7:0] CODE_NVM_RESTORE = 8'h12;
	localparam logic [7:0] CODE_FEATURE = 8'h19;
	localparam logic [7:0] CODE_OUT_FORMAT = 8'h20;
	localparam logic [7:0] CODE_VOUT_SET = 8'h21;
	localparam logic [7:0] CODE_VOUT_CEIL = 8'h24;
	localparam logic [7:0] CODE_OC_TRIP = 8'h46;
	localparam logic [7:0] CODE_OC_WARN = 8'h4a;
	// ------------------------------------------------------------
	// write guard levels and fields
	// ------------------------------------------------------------
	localparam logic [7:0] GUARD_NONE = 8'h00;
	localparam logic [7:0] GUARD_ALL = 8'h80;
	localparam logic [7:0] GUARD_ALLOW_ONOFF = 8'h40;
	localparam logic [7:0] GUARD_ALLOW_CONFIG = 8'h20;
	localparam logic [7:0] GUARD_FIELD_MASK = 8'he0;
	localparam logic [7:0] GUARD_RESET = 8'h00;
	// ------------------------------------------------------------
	// read-only bytes
	// ------------------------------------------------------------
	localparam logic [7:0] FEATURE_VALUE = 8'hb0;
	localparam logic [2:0] FORMAT_MODE_VID = 3'h1;
	localparam logic [4:0] FORMAT_PARAM_NEW = 5'h02;
	localparam logic [4:0] FORMAT_PARAM_OLD = 5'h01;
	// ------------------------------------------------------------
	// operating memory items and their fixed values
	// ------------------------------------------------------------
	localparam int PNC_ITEMS = 6;
	localparam int IDX_OPERATION = 0;
	localparam int IDX_ON_OFF_CFG = 1;
	localparam int IDX_VOUT_SET = 2;
	localparam int IDX_VOUT_CEIL = 3;
	localparam int IDX_OC_TRIP = 4;
	localparam int IDX_OC_WARN = 5;
	// items with a matching default-store location
	localparam logic [PNC_ITEMS-1:0] NVM_MATCH = 6'h3e;
	localparam logic [7:0] RATED_MAX_CURRENT = 8'h40;
	localparam logic [7:0] STARTUP_VOLTAGE_CODE = 8'h80;
	localparam logic [9:0] OC_TRIP_WIDE = (10'(RATED_MAX_CURRENT) * 10'h005) >> 2;
	localparam logic [7:0] OC_TRIP_DEFAULT = OC_TRIP_WIDE[7:0];
	localparam logic [7:0] VOUT_CEIL_DEFAULT = 8'hff;
	localparam logic [7:0] OPERATION_RESET = 8'h00;
	localparam logic [7:0] ON_OFF_CFG_RESET = 8'h17;
	localparam logic [7:0] ITEM_RESET [PNC_ITEMS] = '{OPERATION_RESET, ON_OFF_CFG_RESET,
		STARTUP_VOLTAGE_CODE, VOUT_CEIL_DEFAULT, OC_TRIP_DEFAULT, RATED_MAX_CURRENT};
	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_STORE = 2'b01,
		ST_RESTORE = 2'b10
	} pnc_state_e;
endpackage : pnc_pkg

// [pnc_cmd_handler.sv]
// Purpose: write guard, default-store copy commands and read-only bytes
// Assumes: the bus front end hands over one decoded command per pulse
// Notes: all outputs are registered; the table select pin is synchronised
// Notes on behaviour
// - guard 80h: only writes to the guard command itself are accepted.
// - guard 40h: only guard and operation writes are accepted.
// - guard 20h: guard, operation and on/off config writes accepted.
// - guard 00h, the reset value: every writable command is accepted.
// - any guard value besides 00h or one of bits 7..5 is invalid; the handler keeps only bits 7..5 of a written value, so 81h acts as 80h.
// - a data write accepted under an invalid guard sets both communication flags; no guard applies.
// - store copies items with a default location, skips the rest.
// - after store: trip 125% of max current, warning, boot voltage, ceiling ffh.
// - store and restore are bare command codes with no data byte.
// - restore overwrites each item from its default location, except operation, which has none.
// - restore ignores default entries with no operating item.
// - feature byte is constant with top bit set for error checking.
// - feature bits 6..5 read 01 for 400 kHz bus speed.
// - feature bit 4 reads 1 for alert support, bits 3..0 zero.
// - output format byte: mode over parameter, reset value 21h.
// - writes to the output format byte are refused, and flagged unless a guard level refuses them first.
// - mode reads 001; parameter 00010 new table, 00001 old.
module pnc_cmd_handler (
	input wire logic SYS_CLK,
	input wire logic SRST,
	input wire logic CMD_WR,
	input wire logic CMD_RD,
	input wire logic CMD_HAS_DATA,
	input wire logic [7:0] CMD_CODE,
	input wire logic [7:0] CMD_DATA,
	input wire logic FLAG_CLEAR,
	input wire logic TABLE_SEL_PIN,
	output logic [7:0] RD_DATA,
	output logic RD_VALID,
	output logic WR_ACCEPT,
	output logic WR_REJECT,
	output logic BUSY,
	output logic COMM_SUMMARY_FLAG,
	output logic UNSUPPORTED_DATA_FLAG,
	output logic [7:0] VOUT_SET_Q,
	output logic [7:0] OC_TRIP_Q
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	pnc_pkg::pnc_state_e state_r;
	logic [2:0] guard_r;
	logic [7:0] item_r [pnc_pkg::PNC_ITEMS];
	logic [7:0] nvm_r [pnc_pkg::PNC_ITEMS];
	logic sel_meta_r;
	logic sel_r;
	logic [7:0] rd_data_r;
	logic rd_valid_r;
	logic wr_accept_r;
	logic wr_reject_r;
	logic comm_r;
	logic usdata_r;
	logic busy_r;
	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic [7:0] guard_byte;
	logic guard_valid;
	logic idle;
	logic is_item;
	int unsigned item_idx;
	logic is_ro;
	logic guard_ok;
	logic do_write;
	logic do_store;
	logic do_restore;
	logic bad_data;
	logic bad_cmd;
	logic do_clear;

	assign guard_byte = {guard_r, 5'h00};
	assign idle = (state_r == pnc_pkg::ST_IDLE);

	// exactly one of bits 7..5 or none
	always_comb begin
		unique case (guard_byte)
			pnc_pkg::GUARD_NONE, pnc_pkg::GUARD_ALL,
			pnc_pkg::GUARD_ALLOW_ONOFF, pnc_pkg::GUARD_ALLOW_CONFIG: guard_valid = 1'b1;
			default: guard_valid = 1'b0;
		endcase
	end

	always_comb begin
		is_item = 1'b1;
		item_idx = 0;
		unique case (CMD_CODE)
			pnc_pkg::CODE_OPERATION: item_idx = pnc_pkg::IDX_OPERATION;
			pnc_pkg::CODE_ON_OFF_CFG: item_idx = pnc_pkg::IDX_ON_OFF_CFG;
			pnc_pkg::CODE_VOUT_SET: item_idx = pnc_pkg::IDX_VOUT_SET;
			pnc_pkg::CODE_VOUT_CEIL: item_idx = pnc_pkg::IDX_VOUT_CEIL;
			pnc_pkg::CODE_OC_TRIP: item_idx = pnc_pkg::IDX_OC_TRIP;
			pnc_pkg::CODE_OC_WARN: item_idx = pnc_pkg::IDX_OC_WARN;
			default: is_item = 1'b0;
		endcase
	end

	assign is_ro = (CMD_CODE == pnc_pkg::CODE_FEATURE) || (CMD_CODE == pnc_pkg::CODE_OUT_FORMAT);

	// an invalid guard byte protects nothing
	always_comb begin
		guard_ok = 1'b1;
		if (guard_valid) begin
			unique case (guard_byte)
				pnc_pkg::GUARD_ALL: guard_ok = (CMD_CODE == pnc_pkg::CODE_WRITE_GUARD);
				pnc_pkg::GUARD_ALLOW_ONOFF: guard_ok = (CMD_CODE == pnc_pkg::CODE_WRITE_GUARD) ||
					(CMD_CODE == pnc_pkg::CODE_OPERATION);
				pnc_pkg::GUARD_ALLOW_CONFIG: guard_ok = (CMD_CODE == pnc_pkg::CODE_WRITE_GUARD) ||
					(CMD_CODE == pnc_pkg::CODE_OPERATION) ||
					(CMD_CODE == pnc_pkg::CODE_ON_OFF_CFG);
				default: guard_ok = 1'b1;
			endcase
		end
	end

	// store and restore need no data byte; one sent anyway is ignored
	assign do_store = CMD_WR && idle && guard_ok && (CMD_CODE == pnc_pkg::CODE_NVM_STORE);
	assign do_restore = CMD_WR && idle && guard_ok &&
		(CMD_CODE == pnc_pkg::CODE_NVM_RESTORE);
	assign do_write = CMD_WR && idle && guard_ok && CMD_HAS_DATA &&
		(is_item || (CMD_CODE == pnc_pkg::CODE_WRITE_GUARD));
	assign bad_data = CMD_WR && idle && guard_ok && CMD_HAS_DATA && is_ro;
	assign bad_cmd = CMD_WR && idle && guard_ok && !do_store && !do_restore && !do_write &&
		!bad_data && (CMD_CODE != pnc_pkg::CODE_CLEAR_FLAGS);
	// clearing the flags is a host write as well, so a guard level refuses it
	assign do_clear = CMD_WR && idle && guard_ok &&
		(CMD_CODE == pnc_pkg::CODE_CLEAR_FLAGS);

	// ------------------------------------------------------------
	// table select pin synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			sel_meta_r <= 1'b0;
			sel_r <= 1'b0;
		end else begin
			sel_meta_r <= TABLE_SEL_PIN;
			sel_r <= sel_meta_r;
		end
	end

	// ------------------------------------------------------------
	// sequencer: a copy takes the cycle after the command
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			state_r <= pnc_pkg::ST_IDLE;
			busy_r <= 1'b0;
		end else begin
			// a copy lasts exactly one cycle, so busy mirrors the accepted command
			busy_r <= do_store || do_restore;
			unique case (state_r)
				pnc_pkg::ST_IDLE: begin
					if (do_store) begin
						state_r <= pnc_pkg::ST_STORE;
					end else if (do_restore) begin
						state_r <= pnc_pkg::ST_RESTORE;
					end
				end
				pnc_pkg::ST_STORE, pnc_pkg::ST_RESTORE: state_r <= pnc_pkg::ST_IDLE;
				default: state_r <= pnc_pkg::ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// write guard register
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			guard_r <= pnc_pkg::GUARD_RESET[7:5];
		end else if (do_write && CMD_CODE == pnc_pkg::CODE_WRITE_GUARD) begin
			guard_r <= CMD_DATA[7:5];
		end
	end

	// ------------------------------------------------------------
	// operating memory and default store, one slice per item
	// ------------------------------------------------------------
	for (genvar i = 0; i < pnc_pkg::PNC_ITEMS; i++) begin : g_item
		always_ff @(posedge SYS_CLK) begin
			if (SRST) begin
				item_r[i] <= pnc_pkg::ITEM_RESET[i];
			end else if (state_r == pnc_pkg::ST_STORE) begin
				// these items snap back whatever was just stored
				if (i == pnc_pkg::IDX_OC_TRIP) begin
					item_r[i] <= pnc_pkg::OC_TRIP_DEFAULT;
				end else if (i == pnc_pkg::IDX_OC_WARN) begin
					item_r[i] <= pnc_pkg::RATED_MAX_CURRENT;
				end else if (i == pnc_pkg::IDX_VOUT_SET) begin
					item_r[i] <= pnc_pkg::STARTUP_VOLTAGE_CODE;
				end else if (i == pnc_pkg::IDX_VOUT_CEIL) begin
					item_r[i] <= pnc_pkg::VOUT_CEIL_DEFAULT;
				end
			end else if (state_r == pnc_pkg::ST_RESTORE && pnc_pkg::NVM_MATCH[i]) begin
				item_r[i] <= nvm_r[i];
			end else if (do_write && is_item && item_idx == i) begin
				item_r[i] <= CMD_DATA;
			end
		end
		// the default store has no reset: it models retained contents
		always_ff @(posedge SYS_CLK) begin
			if (state_r == pnc_pkg::ST_STORE && pnc_pkg::NVM_MATCH[i]) begin
				nvm_r[i] <= item_r[i];
			end
		end
	end

	// ------------------------------------------------------------
	// communication flags: set wins over clear
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			comm_r <= 1'b0;
			usdata_r <= 1'b0;
		end else begin
			if (bad_data || bad_cmd || (do_write && !guard_valid)) begin
				comm_r <= 1'b1;
			end else if (FLAG_CLEAR || do_clear) begin
				comm_r <= 1'b0;
			end
			if (bad_data || (do_write && !guard_valid)) begin
				usdata_r <= 1'b1;
			end else if (FLAG_CLEAR || do_clear) begin
				usdata_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// write answer and read path
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			wr_accept_r <= 1'b0;
			wr_reject_r <= 1'b0;
		end else begin
			wr_accept_r <= do_write || do_store || do_restore || do_clear;
			wr_reject_r <= CMD_WR &&
				!(do_write || do_store || do_restore || do_clear);
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			rd_data_r <= 8'h00;
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= CMD_RD;
			if (CMD_RD) begin
				if (CMD_CODE == pnc_pkg::CODE_FEATURE) begin
					rd_data_r <= pnc_pkg::FEATURE_VALUE;
				end else if (CMD_CODE == pnc_pkg::CODE_OUT_FORMAT) begin
					rd_data_r <= {pnc_pkg::FORMAT_MODE_VID,
						sel_r ? pnc_pkg::FORMAT_PARAM_NEW : pnc_pkg::FORMAT_PARAM_OLD};
				end else if (CMD_CODE == pnc_pkg::CODE_WRITE_GUARD) begin
					rd_data_r <= guard_byte;
				end else if (is_item) begin
					rd_data_r <= item_r[item_idx];
				end else begin
					rd_data_r <= 8'h00;
				end
			end
		end
	end

	assign RD_DATA = rd_data_r;
	assign RD_VALID = rd_valid_r;
	assign WR_ACCEPT = wr_accept_r;
	assign WR_REJECT = wr_reject_r;
	assign BUSY = busy_r;
	assign COMM_SUMMARY_FLAG = comm_r;
	assign UNSUPPORTED_DATA_FLAG = usdata_r;
	assign VOUT_SET_Q = item_r[pnc_pkg::IDX_VOUT_SET];
	assign OC_TRIP_Q = item_r[pnc_pkg::IDX_OC_TRIP];

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_store_cmd;
		do_store;
	endsequence
	sequence s_store_done;
		##2 (item_r[pnc_pkg::IDX_OC_TRIP] == pnc_pkg::OC_TRIP_DEFAULT) &&
			(item_r[pnc_pkg::IDX_VOUT_CEIL] == pnc_pkg::VOUT_CEIL_DEFAULT);
	endsequence

	AST_GUARD_ALL: assert property (@(posedge SYS_CLK) disable iff (SRST)
		(CMD_WR && guard_byte == pnc_pkg::GUARD_ALL && CMD_CODE != pnc_pkg::CODE_WRITE_GUARD)
		|=> WR_REJECT) else $error("guard all let a write through");
	AST_GUARD_ONOFF: assert property (@(posedge SYS_CLK) disable iff (SRST)
		(CMD_WR && guard_byte == pnc_pkg::GUARD_ALLOW_ONOFF && CMD_CODE == pnc_pkg::CODE_ON_OFF_CFG)
		|=> WR_REJECT && $stable(item_r[pnc_pkg::IDX_ON_OFF_CFG]))
		else $error("guard level 40h accepted on/off config");
	AST_GUARD_CONFIG: assert property (@(posedge SYS_CLK) disable iff (SRST)
		(CMD_WR && CMD_HAS_DATA && idle && guard_byte == pnc_pkg::GUARD_ALLOW_CONFIG &&
		CMD_CODE == pnc_pkg::CODE_ON_OFF_CFG) |=> WR_ACCEPT)
		else $error("guard level 20h refused on/off config");
	AST_GUARD_INVALID: assert property (@(posedge SYS_CLK) disable iff (SRST)
		(CMD_WR && CMD_HAS_DATA && idle && !guard_valid && CMD_CODE == pnc_pkg::CODE_VOUT_SET)
		|=> WR_ACCEPT && COMM_SUMMARY_FLAG && UNSUPPORTED_DATA_FLAG)
		else $error("invalid guard not flagged or still protecting");
	AST_GUARD_LOW_ZERO: assert property (@(posedge SYS_CLK) disable iff (SRST)
		$past(CMD_RD) && $past(CMD_CODE) == pnc_pkg::CODE_WRITE_GUARD |-> RD_DATA[4:0] == 5'h00)
		else $error("guard low bits not zero");
	AST_STORE_DEFAULTS: assert property (@(posedge SYS_CLK) disable iff (SRST)
		s_store_cmd |-> s_store_done) else $error("store left limits unset");
	AST_RESTORE_COPY: assert property (@(posedge SYS_CLK) disable iff (SRST)
		state_r == pnc_pkg::ST_RESTORE |=> item_r[pnc_pkg::IDX_VOUT_SET] ==
		$past(nvm_r[pnc_pkg::IDX_VOUT_SET])) else $error("restore did not copy");
	AST_FEATURE_READ: assert property (@(posedge SYS_CLK) disable iff (SRST)
		CMD_RD && CMD_CODE == pnc_pkg::CODE_FEATURE |=> RD_VALID && RD_DATA == 8'hb0)
		else $error("feature byte wrong");
	AST_FORMAT_REFUSE: assert property (@(posedge SYS_CLK) disable iff (SRST)
		CMD_WR && CMD_HAS_DATA && idle && guard_ok && CMD_CODE == pnc_pkg::CODE_OUT_FORMAT
		|=> WR_REJECT && COMM_SUMMARY_FLAG && UNSUPPORTED_DATA_FLAG)
		else $error("format byte write not refused");
	AST_FORMAT_READ: assert property (@(posedge SYS_CLK) disable iff (SRST)
		CMD_RD && CMD_CODE == pnc_pkg::CODE_OUT_FORMAT |=> RD_DATA[7:5] == 3'b001 &&
		RD_DATA[4:0] == ($past(sel_r) ? 5'b00010 : 5'b00001)) else $error("format byte wrong");
endmodule : pnc_cmd_handler

// [pnc_host_model.sv]
// Purpose: host-side model that issues write, send-byte and read commands to the handler
// Assumes: called at a falling edge; each task ends at a falling edge
// Notes: released data lines show the inverse of the last value, never a stale copy
module pnc_host_model (
	input wire logic clk,
	output logic cmd_wr,
	output logic cmd_rd,
	output logic cmd_has_data,
	output logic [7:0] cmd_code,
	output logic [7:0] cmd_data,
	input wire logic wr_accept,
	input wire logic wr_reject,
	input wire logic rd_valid,
	input wire logic [7:0] rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		cmd_has_data = 1'b0;
		cmd_code = 8'h00;
		cmd_data = 8'h00;
	end
	// ------------------------------------------------------------
	// command tasks
	// ------------------------------------------------------------
	// last=0 keeps the strobe up so the next call lands on the very next edge
	// a released strobe idles one cycle, so no line is driven twice in one time step
	task automatic wr(input logic [7:0] code, input logic [7:0] data, input logic has,
		input logic last, output logic acc, output logic rej);
		cmd_wr = 1'b1;
		cmd_code = code;
		cmd_has_data = has;
		cmd_data = has ? data : ~cmd_data;
		@(negedge clk);
		acc = wr_accept;
		rej = wr_reject;
		if (last) begin
			cmd_wr = 1'b0;
			cmd_has_data = 1'b0;
			cmd_code = ~code;
			cmd_data = ~cmd_data;
			@(negedge clk);
		end
	endtask : wr
	task automatic rd(input logic [7:0] code, output logic vld, output logic [7:0] d);
		cmd_rd = 1'b1;
		cmd_code = code;
		@(negedge clk);
		vld = rd_valid;
		d = rd_data;
		cmd_rd = 1'b0;
		cmd_code = ~code;
		@(negedge clk);
	endtask : rd
endmodule : pnc_host_model

// [tb_pmbus_protect_nvm_cmds.sv]
// Purpose: self-checking bench for the guard, default-store and read-only command handler
// Assumes: inputs change at falling edges; answers are sampled one falling edge later
// Notes: expected values come from the package constants and the documented figures
module tb_pmbus_protect_nvm_cmds;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, srst = 1'b1, flag_clear = 1'b0, table_sel = 1'b0;
	logic cmd_wr, cmd_rd, has, wr_acc, wr_rej, rd_vld, busy, f_sum, f_uns;
	logic [7:0] code, data, rd_data, vout_q, trip_q;
	int num_errors = 0;
	int cmp_count = 0;
	always #10 clk = ~clk;
	pnc_cmd_handler dut (.SYS_CLK(clk), .SRST(srst), .CMD_WR(cmd_wr), .CMD_RD(cmd_rd),
		.CMD_HAS_DATA(has), .CMD_CODE(code), .CMD_DATA(data), .FLAG_CLEAR(flag_clear),
		.TABLE_SEL_PIN(table_sel), .RD_DATA(rd_data), .RD_VALID(rd_vld), .WR_ACCEPT(wr_acc),
		.WR_REJECT(wr_rej), .BUSY(busy), .COMM_SUMMARY_FLAG(f_sum),
		.UNSUPPORTED_DATA_FLAG(f_uns), .VOUT_SET_Q(vout_q), .OC_TRIP_Q(trip_q));
	pnc_host_model host (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_has_data(has),
		.cmd_code(code), .cmd_data(data), .wr_accept(wr_acc), .wr_reject(wr_rej),
		.rd_valid(rd_vld), .rd_data(rd_data));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic results();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results
	task automatic wr_chk(input logic [7:0] c, input logic [7:0] d, input logic h,
		input logic exp_acc);
		logic a, r;
		host.wr(c, d, h, 1'b1, a, r);
		check({7'h00, a}, {7'h00, exp_acc});
		check({7'h00, r}, {7'h00, ~exp_acc});
	endtask : wr_chk
	task automatic rd_chk(input logic [7:0] c, input logic [7:0] exp);
		logic v;
		logic [7:0] d;
		host.rd(c, v, d);
		check({7'h00, v}, 8'h01);
		check(d, exp);
	endtask : rd_chk
	task automatic flags_chk(input logic s, input logic u);
		check({6'h00, f_sum, f_uns}, {6'h00, s, u});
	endtask : flags_chk
	task automatic clear_flags();
		flag_clear = 1'b1;
		@(negedge clk);
		flag_clear = 1'b0;
		@(negedge clk);
		flags_chk(1'b0, 1'b0);
	endtask : clear_flags
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		check(vout_q, pnc_pkg::STARTUP_VOLTAGE_CODE);
		check(trip_q, 8'h50);
		flags_chk(1'b0, 1'b0);
		rd_chk(pnc_pkg::CODE_WRITE_GUARD, 8'h00);
	endtask : t_reset
	task automatic t_ro_bytes();
		logic v;
		logic [7:0] d;
		host.rd(pnc_pkg::CODE_FEATURE, v, d);
		check(d, 8'hb0);
		check({6'h00, d[6:5]}, 8'h01);
		check({3'h0, d[4:0]}, 8'h10);
		table_sel = 1'b1;
		repeat (4) @(negedge clk);
		rd_chk(pnc_pkg::CODE_OUT_FORMAT, 8'h22);
		table_sel = 1'b0;
		repeat (4) @(negedge clk);
		rd_chk(pnc_pkg::CODE_OUT_FORMAT, 8'h21);
	endtask : t_ro_bytes
	task automatic t_refusals();
		wr_chk(pnc_pkg::CODE_OUT_FORMAT, 8'h55, 1'b1, 1'b0);
		flags_chk(1'b1, 1'b1);
		rd_chk(pnc_pkg::CODE_OUT_FORMAT, 8'h21);
		clear_flags();
		// an item code sent bare carries no value and must be refused
		wr_chk(pnc_pkg::CODE_VOUT_SET, 8'h00, 1'b0, 1'b0);
		flags_chk(1'b1, 1'b0);
		check(vout_q, pnc_pkg::STARTUP_VOLTAGE_CODE);
		wr_chk(pnc_pkg::CODE_CLEAR_FLAGS, 8'h00, 1'b0, 1'b1);
		flags_chk(1'b0, 1'b0);
		clear_flags();
	endtask : t_refusals
	task automatic t_guard_levels();
		logic [7:0] lvl [4] = '{8'h80, 8'h40, 8'h20, 8'h00};
		logic [3:0] allow [4] = '{4'b0000, 4'b0001, 4'b0011, 4'b1111};
		logic [7:0] cds [4] = '{8'h01, 8'h02, 8'h21, 8'h46};
		logic [7:0] exp_vout;
		logic [7:0] d;
		exp_vout = vout_q;
		for (int i = 0; i < 4; i++) begin
			wr_chk(pnc_pkg::CODE_WRITE_GUARD, lvl[i], 1'b1, 1'b1);
			rd_chk(pnc_pkg::CODE_WRITE_GUARD, lvl[i]);
			if (i == 0) begin
				wr_chk(pnc_pkg::CODE_CLEAR_FLAGS, 8'h00, 1'b0, 1'b0);
			end
			for (int j = 0; j < 4; j++) begin
				d = 8'h30 + 8'(i * 4 + j);
				wr_chk(cds[j], d, 1'b1, allow[i][j]);
				if (j == 2 && allow[i][j]) begin
					exp_vout = d;
				end
				check(vout_q, exp_vout);
			end
			flags_chk(1'b0, 1'b0);
		end
	endtask : t_guard_levels
	task automatic t_guard_invalid();
		logic [7:0] bad [4] = '{8'h60, 8'ha0, 8'hc0, 8'he0};
		for (int i = 0; i < 4; i++) begin
			wr_chk(pnc_pkg::CODE_WRITE_GUARD, bad[i], 1'b1, 1'b1);
			flags_chk(1'b0, 1'b0);
			wr_chk(pnc_pkg::CODE_VOUT_SET, 8'h66 + 8'(i), 1'b1, 1'b1);
			check(vout_q, 8'h66 + 8'(i));
			flags_chk(1'b1, 1'b1);
			// a guard write taken while invalid flags too, so restore 00h before clearing
			wr_chk(pnc_pkg::CODE_WRITE_GUARD, 8'h00, 1'b1, 1'b1);
			clear_flags();
		end
	endtask : t_guard_invalid
	task automatic t_store_restore();
		logic a, r;
		wr_chk(pnc_pkg::CODE_VOUT_SET, 8'h33, 1'b1, 1'b1);
		wr_chk(pnc_pkg::CODE_OC_TRIP, 8'h44, 1'b1, 1'b1);
		host.wr(pnc_pkg::CODE_NVM_STORE, 8'h00, 1'b0, 1'b0, a, r);
		check({7'h00, a}, 8'h01);
		check({7'h00, busy}, 8'h01);
		// the copy cycle refuses a write that arrives on the very next edge
		host.wr(pnc_pkg::CODE_VOUT_SET, 8'h77, 1'b1, 1'b1, a, r);
		check({6'h00, a, r}, 8'h01);
		check({7'h00, busy}, 8'h00);
		check(vout_q, pnc_pkg::STARTUP_VOLTAGE_CODE);
		check(trip_q, 8'h50);
		wr_chk(pnc_pkg::CODE_VOUT_SET, 8'h55, 1'b1, 1'b1);
		wr_chk(pnc_pkg::CODE_NVM_RESTORE, 8'h00, 1'b0, 1'b1);
		@(negedge clk);
		check(vout_q, 8'h33);
		check(trip_q, 8'h44);
		flags_chk(1'b0, 1'b0);
	endtask : t_store_restore
	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		t_reset();
		t_ro_bytes();
		t_refusals();
		t_guard_levels();
		t_guard_invalid();
		t_store_restore();
		results();
	end
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		results();
	end
endmodule : tb_pmbus_protect_nvm_cmds
